//--- design/mer_motion_irq_route.sv
// Behaviour
// - 3-bit fall threshold, 156..500 mg, reset 000
// - fall duration: 5 low bits plus one msb
// - each duration count is one output period
// - activity event to pin A when routed
// - single knock to pin A when routed
// - wakeup to pin A when routed
// - free-fall to pin A when routed
// - double knock to pin A when routed
// - orientation change to pin A when routed
// - embedded event to pin A when routed
// - hub done to pin A when routed
// - activity event to pin B when routed
// - single knock to pin B when routed
// - wakeup to pin B when routed
// - free-fall to pin B when routed
// - double knock to pin B when routed
// - orientation change to pin B when routed
// - embedded event to pin B when routed
// - pin B alert 6.4 ms before timestamp wrap
// - activity as change pulse or sleep level
`timescale 1ns/1ps

module mer_motion_irq_route #(
  parameter int TS_W = 32,
  parameter int TS_LSB_NS = 25000
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [mer_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [mer_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [mer_pkg::DATA_W-1:0] reg_rdata_out,
  input wire logic odr_tick_in,
  input wire mer_pkg::mer_accel_t accel_in,
  input wire mer_pkg::mer_events_t events_in,
  input wire logic [TS_W-1:0] timestamp_in,
  output logic first_interrupt_pin_out,
  output logic second_interrupt_pin_out
);

  // ----------------------------------------------------------------
  // derived counts and parameter checks
  // ----------------------------------------------------------------
  localparam int WRAP_WARN_CNT =
    (mer_pkg::TS_WARN_NS + TS_LSB_NS - 1) / TS_LSB_NS;

  generate
    if (TS_W < 8 || TS_W > 32) begin : g_bad_ts_w
      $error("timestamp width must be 8 to 32");
    end
    if (TS_LSB_NS < 1) begin : g_bad_lsb
      $error("timestamp step must be positive");
    end
    if (TS_W < 32) begin : g_chk_range
      if (WRAP_WARN_CNT >= (1 << TS_W)) begin : g_bad_warn
        $error("warning window exceeds timestamp range");
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // package consistency checks
  // ----------------------------------------------------------------
  localparam int FALL_FIELDS_W = mer_pkg::FALL_THS_W + mer_pkg::FALL_DUR_W;
  localparam int FALL_TOTAL_W = mer_pkg::FALL_DUR_W + 1;

  generate
    if (mer_pkg::ADDR_W != 8 || mer_pkg::DATA_W != 8) begin : g_bad_bus
      $error("register bus must be eight bits wide");
    end
    if (FALL_FIELDS_W != mer_pkg::DATA_W) begin : g_bad_fields
      $error("fall fields must fill one register");
    end
    if (mer_pkg::FALL_CNT_W != FALL_TOTAL_W) begin : g_bad_count
      $error("fall counter must hold the six-bit duration");
    end
    if (mer_pkg::ACC_W < 9) begin : g_bad_acc
      $error("axis width too small for the largest threshold");
    end
    if (mer_pkg::FALL_DUR_MSB_BIT >= mer_pkg::DATA_W) begin : g_bad_msb
      $error("duration msb outside its register");
    end
    if (mer_pkg::ROUTE_ACTIVITY_BIT >= mer_pkg::DATA_W) begin : g_bad_route
      $error("routing bit outside its register");
    end
    if (mer_pkg::STAT_PIN_B_BIT >= mer_pkg::DATA_W) begin : g_bad_status
      $error("status bit outside its register");
    end
  endgenerate

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] tap_cfg;
  logic [7:0] wake_dur;
  logic [7:0] free_fall_config;
  logic [7:0] first_pin_event_routing;
  logic [7:0] second_pin_event_routing;
  logic [mer_pkg::FALL_CNT_W-1:0] fall_count;
  logic fall_flag;
  logic wrap_alert;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire hit_tap = reg_addr_in == mer_pkg::TAP_CFG_ADDR;
  wire hit_wake = reg_addr_in == mer_pkg::WAKE_DUR_ADDR;
  wire hit_fall = reg_addr_in == mer_pkg::FALL_CFG_ADDR;
  wire hit_pin_a = reg_addr_in == mer_pkg::PIN_A_ROUTE_ADDR;
  wire hit_pin_b = reg_addr_in == mer_pkg::PIN_B_ROUTE_ADDR;
  wire hit_status = reg_addr_in == mer_pkg::STATUS_ADDR;

  wire wr_tap = reg_write_in && hit_tap;
  wire wr_wake = reg_write_in && hit_wake;
  wire wr_fall = reg_write_in && hit_fall;
  wire wr_pin_a = reg_write_in && hit_pin_a;
  wire wr_pin_b = reg_write_in && hit_pin_b;

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tap_cfg <= mer_pkg::TAP_CFG_RST;
      wake_dur <= mer_pkg::WAKE_DUR_RST;
      free_fall_config <= mer_pkg::FALL_CFG_RST;
      first_pin_event_routing <= mer_pkg::PIN_A_ROUTE_RST;
      second_pin_event_routing <= mer_pkg::PIN_B_ROUTE_RST;
    end else begin
      if (wr_tap) begin
        tap_cfg <= reg_wdata_in;
      end
      if (wr_wake) begin
        wake_dur <= reg_wdata_in;
      end
      if (wr_fall) begin
        free_fall_config <= reg_wdata_in;
      end
      if (wr_pin_a) begin
        first_pin_event_routing <= reg_wdata_in;
      end
      if (wr_pin_b) begin
        second_pin_event_routing <= reg_wdata_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // free-fall settings
  // ----------------------------------------------------------------
  wire [mer_pkg::FALL_THS_W-1:0] fall_threshold_field =
    free_fall_config[mer_pkg::FALL_THS_LSB +: mer_pkg::FALL_THS_W];
  wire [mer_pkg::FALL_DUR_W-1:0] fall_duration_field =
    free_fall_config[mer_pkg::FALL_DUR_LSB +: mer_pkg::FALL_DUR_W];
  wire fall_duration_msb = wake_dur[mer_pkg::FALL_DUR_MSB_BIT];

  // six-bit duration in output periods
  wire [mer_pkg::FALL_CNT_W-1:0] fall_duration =
    {fall_duration_msb, fall_duration_field};

  wire [mer_pkg::ACC_W-1:0] fall_limit_mg =
    mer_pkg::fall_ths_mg(fall_threshold_field);

  // all three axes below the limit
  wire axes_low = (accel_in.x < fall_limit_mg)
    && (accel_in.y < fall_limit_mg)
    && (accel_in.z < fall_limit_mg);

  wire fall_count_full = &fall_count;
  wire fall_long_enough = fall_count >= fall_duration;

  logic [mer_pkg::FALL_CNT_W-1:0] next_fall_count;
  logic next_fall_flag;

  // counts whole output periods spent below the limit
  always_comb begin
    next_fall_count = fall_count;
    next_fall_flag = fall_flag;
    if (odr_tick_in) begin
      if (!axes_low) begin
        next_fall_count = '0;
        next_fall_flag = 1'b0;
      end else begin
        next_fall_flag = fall_flag || fall_long_enough;
        if (!fall_count_full) begin
          next_fall_count = fall_count + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fall_count <= '0;
      fall_flag <= 1'b0;
    end else begin
      fall_count <= next_fall_count;
      fall_flag <= next_fall_flag;
    end
  end

  // ----------------------------------------------------------------
  // timestamp wrap warning
  // ----------------------------------------------------------------
  localparam logic [TS_W-1:0] WRAP_WARN = TS_W'(WRAP_WARN_CNT);

  // steps left before the counter rolls over
  wire [TS_W-1:0] ts_remaining = ~timestamp_in;
  wire next_wrap_alert = ts_remaining < WRAP_WARN;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wrap_alert <= 1'b0;
    end else begin
      wrap_alert <= next_wrap_alert;
    end
  end

  // ----------------------------------------------------------------
  // event sources
  // ----------------------------------------------------------------
  wire sleep_level_mode = tap_cfg[mer_pkg::SLEEP_SEL_BIT];
  wire activity_evt = sleep_level_mode ? events_in.sleep_state
    : events_in.activity_change;

  logic [7:0] src_a;
  logic [7:0] src_b;

  always_comb begin
    src_a = '0;
    src_a[mer_pkg::ROUTE_ACTIVITY_BIT] = activity_evt;
    src_a[mer_pkg::ROUTE_SINGLE_BIT] = events_in.single_knock;
    src_a[mer_pkg::ROUTE_WAKEUP_BIT] = events_in.wakeup;
    src_a[mer_pkg::ROUTE_FALL_BIT] = fall_flag;
    src_a[mer_pkg::ROUTE_DOUBLE_BIT] = events_in.double_knock;
    src_a[mer_pkg::ROUTE_ORIENT_BIT] =
      events_in.six_direction_orientation;
    src_a[mer_pkg::ROUTE_EMBEDDED_BIT] = events_in.embedded;
    src_a[mer_pkg::ROUTE_LAST_BIT] = events_in.hub_done;
  end

  always_comb begin
    src_b = src_a;
    src_b[mer_pkg::ROUTE_LAST_BIT] = wrap_alert;
  end

  // ----------------------------------------------------------------
  // routing masks
  // ----------------------------------------------------------------
  wire pin_a_activity_route =
    first_pin_event_routing[mer_pkg::ROUTE_ACTIVITY_BIT];
  wire pin_a_single_knock_route =
    first_pin_event_routing[mer_pkg::ROUTE_SINGLE_BIT];
  wire pin_a_wakeup_route =
    first_pin_event_routing[mer_pkg::ROUTE_WAKEUP_BIT];
  wire pin_a_fall_route =
    first_pin_event_routing[mer_pkg::ROUTE_FALL_BIT];
  wire pin_a_double_knock_route =
    first_pin_event_routing[mer_pkg::ROUTE_DOUBLE_BIT];
  wire pin_a_orientation_route =
    first_pin_event_routing[mer_pkg::ROUTE_ORIENT_BIT];
  wire pin_a_embedded_route =
    first_pin_event_routing[mer_pkg::ROUTE_EMBEDDED_BIT];
  wire pin_a_hub_done_route =
    first_pin_event_routing[mer_pkg::ROUTE_LAST_BIT];

  wire pin_b_activity_route =
    second_pin_event_routing[mer_pkg::ROUTE_ACTIVITY_BIT];
  wire pin_b_single_knock_route =
    second_pin_event_routing[mer_pkg::ROUTE_SINGLE_BIT];
  wire pin_b_wakeup_route =
    second_pin_event_routing[mer_pkg::ROUTE_WAKEUP_BIT];
  wire pin_b_fall_route =
    second_pin_event_routing[mer_pkg::ROUTE_FALL_BIT];
  wire pin_b_double_knock_route =
    second_pin_event_routing[mer_pkg::ROUTE_DOUBLE_BIT];
  wire pin_b_orientation_route =
    second_pin_event_routing[mer_pkg::ROUTE_ORIENT_BIT];
  wire pin_b_embedded_route =
    second_pin_event_routing[mer_pkg::ROUTE_EMBEDDED_BIT];
  wire pin_b_time_wrap_route =
    second_pin_event_routing[mer_pkg::ROUTE_LAST_BIT];

  // ----------------------------------------------------------------
  // gated events per pin
  // ----------------------------------------------------------------
  wire a_activity = pin_a_activity_route
    && src_a[mer_pkg::ROUTE_ACTIVITY_BIT];
  wire a_single = pin_a_single_knock_route
    && src_a[mer_pkg::ROUTE_SINGLE_BIT];
  wire a_wakeup = pin_a_wakeup_route
    && src_a[mer_pkg::ROUTE_WAKEUP_BIT];
  wire a_fall = pin_a_fall_route
    && src_a[mer_pkg::ROUTE_FALL_BIT];
  wire a_double = pin_a_double_knock_route
    && src_a[mer_pkg::ROUTE_DOUBLE_BIT];
  wire a_orient = pin_a_orientation_route
    && src_a[mer_pkg::ROUTE_ORIENT_BIT];
  wire a_embedded = pin_a_embedded_route
    && src_a[mer_pkg::ROUTE_EMBEDDED_BIT];
  wire a_hub = pin_a_hub_done_route
    && src_a[mer_pkg::ROUTE_LAST_BIT];

  wire b_activity = pin_b_activity_route
    && src_b[mer_pkg::ROUTE_ACTIVITY_BIT];
  wire b_single = pin_b_single_knock_route
    && src_b[mer_pkg::ROUTE_SINGLE_BIT];
  wire b_wakeup = pin_b_wakeup_route
    && src_b[mer_pkg::ROUTE_WAKEUP_BIT];
  wire b_fall = pin_b_fall_route
    && src_b[mer_pkg::ROUTE_FALL_BIT];
  wire b_double = pin_b_double_knock_route
    && src_b[mer_pkg::ROUTE_DOUBLE_BIT];
  wire b_orient = pin_b_orientation_route
    && src_b[mer_pkg::ROUTE_ORIENT_BIT];
  wire b_embedded = pin_b_embedded_route
    && src_b[mer_pkg::ROUTE_EMBEDDED_BIT];
  wire b_wrap = pin_b_time_wrap_route
    && src_b[mer_pkg::ROUTE_LAST_BIT];

  // ----------------------------------------------------------------
  // pin merge
  // ----------------------------------------------------------------
  wire next_pin_a = a_activity || a_single || a_wakeup || a_fall
    || a_double || a_orient || a_embedded || a_hub;
  wire next_pin_b = b_activity || b_single || b_wakeup || b_fall
    || b_double || b_orient || b_embedded || b_wrap;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      first_interrupt_pin_out <= 1'b0;
      second_interrupt_pin_out <= 1'b0;
    end else begin
      first_interrupt_pin_out <= next_pin_a;
      second_interrupt_pin_out <= next_pin_b;
    end
  end

  // ----------------------------------------------------------------
  // status and read-back
  // ----------------------------------------------------------------
  logic [7:0] status_word;

  always_comb begin
    status_word = '0;
    status_word[mer_pkg::STAT_FALL_BIT] = fall_flag;
    status_word[mer_pkg::STAT_WRAP_BIT] = wrap_alert;
    status_word[mer_pkg::STAT_PIN_A_BIT] = first_interrupt_pin_out;
    status_word[mer_pkg::STAT_PIN_B_BIT] = second_interrupt_pin_out;
  end

  // unmapped addresses read as zero
  wire [7:0] read_mux =
    hit_tap ? tap_cfg :
    hit_wake ? wake_dur :
    hit_fall ? free_fall_config :
    hit_pin_a ? first_pin_event_routing :
    hit_pin_b ? second_pin_event_routing :
    hit_status ? status_word :
    8'h00;

  // data valid only in the cycle after the strobe
  wire [7:0] next_rdata = reg_read_in ? read_mux : 8'h00;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else begin
      reg_rdata_out <= next_rdata;
    end
  end

endmodule // mer_motion_irq_route

//--- design/mer_pkg.sv
package mer_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] TAP_CFG_ADDR = 8'h56;
  localparam logic [7:0] WAKE_DUR_ADDR = 8'h5C;
  localparam logic [7:0] FALL_CFG_ADDR = 8'h5D;
  localparam logic [7:0] PIN_A_ROUTE_ADDR = 8'h5E;
  localparam logic [7:0] PIN_B_ROUTE_ADDR = 8'h5F;
  localparam logic [7:0] STATUS_ADDR = 8'h7E;

  localparam logic [7:0] TAP_CFG_RST = 8'h00;
  localparam logic [7:0] WAKE_DUR_RST = 8'h00;
  localparam logic [7:0] FALL_CFG_RST = 8'h00;
  localparam logic [7:0] PIN_A_ROUTE_RST = 8'h00;
  localparam logic [7:0] PIN_B_ROUTE_RST = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int FALL_THS_LSB = 0;
  localparam int FALL_THS_W = 3;
  localparam int FALL_DUR_LSB = 3;
  localparam int FALL_DUR_W = 5;
  localparam int FALL_DUR_MSB_BIT = 7;
  localparam int SLEEP_SEL_BIT = 7;
  localparam int ROUTE_ACTIVITY_BIT = 7;
  localparam int ROUTE_SINGLE_BIT = 6;
  localparam int ROUTE_WAKEUP_BIT = 5;
  localparam int ROUTE_FALL_BIT = 4;
  localparam int ROUTE_DOUBLE_BIT = 3;
  localparam int ROUTE_ORIENT_BIT = 2;
  localparam int ROUTE_EMBEDDED_BIT = 1;
  localparam int ROUTE_LAST_BIT = 0;
  localparam int STAT_FALL_BIT = 0;
  localparam int STAT_WRAP_BIT = 1;
  localparam int STAT_PIN_A_BIT = 2;
  localparam int STAT_PIN_B_BIT = 3;

  // ----------------------------------------------------------------
  // timing and scaling
  // ----------------------------------------------------------------
  localparam int TS_WARN_NS = 6400000;
  localparam int ACC_W = 16;
  localparam int FALL_CNT_W = 6;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic activity_change;
    logic sleep_state;
    logic single_knock;
    logic double_knock;
    logic wakeup;
    logic six_direction_orientation;
    logic embedded;
    logic hub_done;
  } mer_events_t;

  typedef struct packed {
    logic [ACC_W-1:0] x;
    logic [ACC_W-1:0] y;
    logic [ACC_W-1:0] z;
  } mer_accel_t;

  // threshold code to milli-g
  function automatic logic [ACC_W-1:0] fall_ths_mg(
    input logic [FALL_THS_W-1:0] code
  );
    case (code)
      3'h0: fall_ths_mg = 16'h009C;
      3'h1: fall_ths_mg = 16'h00DB;
      3'h2: fall_ths_mg = 16'h00FA;
      3'h3: fall_ths_mg = 16'h0138;
      3'h4: fall_ths_mg = 16'h0158;
      3'h5: fall_ths_mg = 16'h0196;
      3'h6: fall_ths_mg = 16'h01D5;
      default: fall_ths_mg = 16'h01F4;
    endcase
  endfunction

endpackage

//--- test/mer_route_properties.sv
`timescale 1ns/1ps
module mer_route_properties #(
  parameter int TS_W = 32,
  parameter int TS_LSB_NS = 25000
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic odr_tick_in,
  input wire mer_pkg::mer_events_t events_in,
  input wire logic [TS_W-1:0] timestamp_in,
  input wire logic first_interrupt_pin_out,
  input wire logic second_interrupt_pin_out
);
  localparam int WRAP_CNT = (6400000 + TS_LSB_NS - 1) / TS_LSB_NS;
  logic [7:0] tap, wdur, fall, ra, rb;
  // ----------
  // register mirror
  // ----------
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tap <= 8'h00;
      wdur <= 8'h00;
      fall <= 8'h00;
      ra <= 8'h00;
      rb <= 8'h00;
    end else if (reg_write_in) begin
      case (reg_addr_in)
        8'h56: tap <= reg_wdata_in;
        8'h5C: wdur <= reg_wdata_in;
        8'h5D: fall <= reg_wdata_in;
        8'h5E: ra <= reg_wdata_in;
        8'h5F: rb <= reg_wdata_in;
        default: ;
      endcase
    end
  end
  wire logic [7:0] rd_exp = (reg_addr_in == 8'h56) ? tap :
    (reg_addr_in == 8'h5C) ? wdur : (reg_addr_in == 8'h5D) ? fall :
    (reg_addr_in == 8'h5E) ? ra : (reg_addr_in == 8'h5F) ? rb : 8'h00;
  wire logic act = tap[7] ? events_in.sleep_state :
    events_in.activity_change;
  wire logic [7:0] ev_a = {act, events_in.single_knock, events_in.wakeup,
    1'b0, events_in.double_knock, events_in.six_direction_orientation,
    events_in.embedded, events_in.hub_done};
  wire logic [7:0] ev_b = {ev_a[7:1], 1'b0};
  wire logic hit_a = |(ev_a & ra);
  wire logic hit_b = |(ev_b & rb);
  wire logic near = (~timestamp_in) < TS_W'(WRAP_CNT);
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_wrap_near;
    rst_n_in && near ##1 rb[0];
  endsequence
  sequence s_wrap_far;
    !near ##1 rb == 8'h01;
  endsequence
  a_read_value: assert property (
    reg_read_in && reg_addr_in != 8'h7E |=> reg_rdata_out == $past(rd_exp))
    else $error("read data differs from register");
  a_pin_a_exact: assert property (
    !ra[4] |=> first_interrupt_pin_out == $past(hit_a))
    else $error("pin A differs from routed events");
  a_pin_a_or: assert property (
    hit_a |=> first_interrupt_pin_out)
    else $error("pin A low with routed event");
  a_pin_b_exact: assert property (
    !rb[4] && !rb[0] |=> second_interrupt_pin_out == $past(hit_b))
    else $error("pin B differs from routed events");
  a_pin_b_or: assert property (
    hit_b |=> second_interrupt_pin_out)
    else $error("pin B low with routed event");
  a_wrap_near: assert property (
    s_wrap_near |=> second_interrupt_pin_out)
    else $error("pin B missing wrap alert");
  a_wrap_far: assert property (
    s_wrap_far |=> !second_interrupt_pin_out)
    else $error("pin B alert too early");
  a_fall_on_tick: assert property (
    ra == 8'h10 && !odr_tick_in ##1 ra == 8'h10
    |=> $stable(first_interrupt_pin_out))
    else $error("fall flag moved without tick");
endmodule // mer_route_properties

bind mer_motion_irq_route mer_route_properties #(
  .TS_W(TS_W), .TS_LSB_NS(TS_LSB_NS)
) u_props (
  .clock_in(clock_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
  .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
  .odr_tick_in(odr_tick_in), .events_in(events_in),
  .timestamp_in(timestamp_in),
  .first_interrupt_pin_out(first_interrupt_pin_out),
  .second_interrupt_pin_out(second_interrupt_pin_out)
);

//--- test/mer_host_model.sv
`timescale 1ns/1ps
// ----------
// host: counts pin rises
// ----------
module mer_host_model (
  input wire logic clock_in,
  input wire logic pin_a_in,
  input wire logic pin_b_in,
  output int rises_a_out,
  output int rises_b_out
);
  logic last_a = 1'b0;
  logic last_b = 1'b0;
  int cnt_a = 0;
  int cnt_b = 0;
  assign rises_a_out = cnt_a;
  assign rises_b_out = cnt_b;
  always @(posedge clock_in) begin
    last_a <= pin_a_in;
    last_b <= pin_b_in;
    if (pin_a_in === 1'b1 && last_a === 1'b0) cnt_a <= cnt_a + 1;
    if (pin_b_in === 1'b1 && last_b === 1'b0) cnt_b <= cnt_b + 1;
  end
endmodule // mer_host_model

//--- test/mer_testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int LSB = 25000;
  localparam int WIN = (6400000 + LSB - 1) / LSB;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [7:0] rdata;
  logic tick_s = 1'b0;
  mer_pkg::mer_accel_t accel = '0;
  mer_pkg::mer_events_t ev = '0;
  logic [31:0] ts = 32'h0000_0000;
  logic pin_a, pin_b;
  int rises_a, rises_b, n0;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  logic [15:0] thr [8] = '{16'h009C, 16'h00DB, 16'h00FA, 16'h0138,
    16'h0158, 16'h0196, 16'h01D5, 16'h01F4};
  logic [7:0] adr [6] = '{8'h56, 8'h5C, 8'h5D, 8'h5E, 8'h5F, 8'h60};

  mer_motion_irq_route #(.TS_W(32), .TS_LSB_NS(LSB)) dut (
    .clock_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_write_in(wr_s), .reg_read_in(rd_s),
    .reg_rdata_out(rdata), .odr_tick_in(tick_s), .accel_in(accel),
    .events_in(ev), .timestamp_in(ts),
    .first_interrupt_pin_out(pin_a), .second_interrupt_pin_out(pin_b));
  mer_host_model host (.clock_in(clk), .pin_a_in(pin_a),
    .pin_b_in(pin_b), .rises_a_out(rises_a), .rises_b_out(rises_b));

  always #10 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      give_verdict();
    end
  end
  // ----------
  // tasks
  // ----------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk({8'h00, rdata}, {8'h00, exp});
    @(posedge clk);
  endtask
  task automatic pins(input logic ea, input logic eb);
    repeat (2) @(posedge clk);
    #1 chk({14'h0, pin_a, pin_b}, {14'h0, ea, eb});
    @(posedge clk);
  endtask
  task automatic tick();
    tick_s <= 1'b1;
    @(posedge clk);
    tick_s <= 1'b0;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  function automatic mer_pkg::mer_events_t ev_of(input int b);
    mer_pkg::mer_events_t e;
    e = '0;
    case (b)
      7: e.activity_change = 1'b1;
      6: e.single_knock = 1'b1;
      5: e.wakeup = 1'b1;
      3: e.double_knock = 1'b1;
      2: e.six_direction_orientation = 1'b1;
      1: e.embedded = 1'b1;
      0: e.hub_done = 1'b1;
      default: e = '0;
    endcase
    return e;
  endfunction
  // ----------
  // main sequence
  // ----------
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (adr[i]) rd(adr[i], 8'h00);
    foreach (adr[i]) wr(adr[i], 8'h5A);
    foreach (adr[i]) rd(adr[i], (i == 5) ? 8'h00 : 8'h5A);
    foreach (adr[i]) wr(adr[i], 8'h00);
    $display("test registers done");
    for (int b = 7; b >= 0; b--) begin
      wr(8'h5E, 8'h01 << b);
      wr(8'h5F, 8'h01 << b);
      ev <= ev_of(b);
      pins(b != 4, b != 4 && b != 0);
      ev <= ~ev_of(b);
      pins(1'b0, 1'b0);
      ev <= '0;
    end
    $display("test routing done");
    wr(8'h56, 8'h80);
    wr(8'h5E, 8'h80);
    wr(8'h5F, 8'hFE);
    ev <= 8'h40;
    pins(1'b1, 1'b1);
    ev <= 8'h80;
    pins(1'b0, 1'b0);
    ev <= '0;
    wr(8'h56, 8'h00);
    $display("test activity mode done");
    wr(8'h5E, 8'h10);
    wr(8'h5F, 8'h10);
    n0 = rises_a;
    for (int c = 0; c < 8; c++) begin
      wr(8'h5D, 8'(c));
      accel <= {3{thr[c]}};
      tick();
      pins(1'b0, 1'b0);
      accel <= {3{thr[c] - 16'h0001}};
      tick();
      pins(1'b1, 1'b1);
    end
    chk(16'(rises_a - n0), 16'h0008);
    $display("test fall threshold done");
    wr(8'h5C, 8'h80);
    wr(8'h5D, 8'h08);
    accel <= {3{16'h01F4}};
    tick();
    pins(1'b0, 1'b0);
    accel <= '0;
    for (int i = 0; i < 34; i++) begin
      tick();
      pins(i == 33, i == 33);
    end
    rd(8'h7E, 8'h0D);
    $display("test fall duration done");
    wr(8'h5E, 8'h00);
    wr(8'h5F, 8'h01);
    n0 = rises_b;
    ts <= ~32'(WIN - 1);
    pins(1'b0, 1'b1);
    rd(8'h7E, 8'h0B);
    ts <= ~32'(WIN);
    pins(1'b0, 1'b0);
    chk(16'(rises_b - n0), 16'h0001);
    $display("test wrap alert done");
    give_verdict();
  end
endmodule // testbench
